// file: vlsc_top.sv
// voltage-code decode, strap decode, ramp, load-line, on-time and input
// current settings; register port and code port come from core_clk logic,
// strap and comparator are pins
`include "vlsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module vlsc_top #(
  parameter logic [6:0] BASE_ADDR = 7'h40,
  parameter int ON_TIME_NS = `VLSC_ON_TIME_NS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire vlsc_pkg::vlsc_reg_req_type reg_req,
  output logic [15:0] reg_rdata_q,
  // voltage code port
  input wire vlsc_pkg::vlsc_code_req_type code_req,
  input wire logic grid_10mv_sel,
  output logic [11:0] setpoint_mv_q,
  output logic output_off_q,
  output logic [3:0] ramp_timing_q,
  output logic ramp_fast_q,
  // strap
  input wire logic [3:0] strap_select_pin,
  output logic strap_done_q,
  output logic [3:0] config_set_q,
  output logic [6:0] bus_addr_q,
  // load line
  output logic [29:0] droop_res_q,
  output logic [9:0] ll_bw_khz_q,
  // on-time pulse
  input wire logic below_thresh,
  output logic hs_gate_q,
  // input current sense
  input wire logic [1:0] iin_sense_mode,
  input wire logic [15:0] iout_ma,
  input wire logic [11:0] vout_mv,
  input wire logic [15:0] vin_mv,
  input wire logic [15:0] shunt_uv,
  output logic use_calc_q,
  output logic use_shunt_q,
  output logic [7:0] rsense_tenth_mohm_q,
  output logic [15:0] iin_ma_q
);
  localparam int ON_CYC_RAW = (ON_TIME_NS * `VLSC_CLK_MHZ) / 1000;
  localparam int ON_CYC = (ON_CYC_RAW < 1) ? 1 : ON_CYC_RAW;

  logic [15:0] slow_ramp_config_q, fast_ramp_config_q;
  logic [15:0] input_current_sense_cfg_q, droop_range_bandwidth_q, droop_resistance_q;
  // register file, each address writes only its own register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_ramp_config_q <= `VLSC_RST_SLOW;
      fast_ramp_config_q <= `VLSC_RST_FAST;
      input_current_sense_cfg_q <= `VLSC_RST_IIN;
      droop_range_bandwidth_q <= `VLSC_RST_LLBW;
      droop_resistance_q <= `VLSC_RST_DROOP;
    end else if (ce && reg_req.wr) begin
      if (reg_req.addr == `VLSC_ADDR_SLOW) begin
        slow_ramp_config_q <= reg_req.wdata;
      end else if (reg_req.addr == `VLSC_ADDR_FAST) begin
        fast_ramp_config_q <= reg_req.wdata;
      end else if (reg_req.addr == `VLSC_ADDR_IIN) begin
        input_current_sense_cfg_q <= reg_req.wdata;
      end else if (reg_req.addr == `VLSC_ADDR_LLBW) begin
        droop_range_bandwidth_q <= reg_req.wdata;
      end else if (reg_req.addr == `VLSC_ADDR_DROOP) begin
        droop_resistance_q <= reg_req.wdata;
      end
    end
  end

  // read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (ce && reg_req.rd) begin
      if (reg_req.addr == `VLSC_ADDR_SLOW) begin
        reg_rdata_q <= slow_ramp_config_q;
      end else if (reg_req.addr == `VLSC_ADDR_FAST) begin
        reg_rdata_q <= fast_ramp_config_q;
      end else if (reg_req.addr == `VLSC_ADDR_IIN) begin
        reg_rdata_q <= input_current_sense_cfg_q;
      end else if (reg_req.addr == `VLSC_ADDR_LLBW) begin
        reg_rdata_q <= droop_range_bandwidth_q;
      end else if (reg_req.addr == `VLSC_ADDR_DROOP) begin
        reg_rdata_q <= droop_resistance_q;
      end else begin
        reg_rdata_q <= 16'h0000;
      end
    end
  end

  // pin synchronisers
  logic [3:0] strap_s1_q, strap_s2_q;
  logic grid_s1_q, grid_s2_q, cmp_s1_q, cmp_s2_q, cmp_s3_q;
  logic [1:0] strap_wait_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
      grid_s1_q <= 1'b0;
      grid_s2_q <= 1'b0;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
    end else if (ce) begin
      strap_s1_q <= strap_select_pin;
      strap_s2_q <= strap_s1_q;
      grid_s1_q <= grid_10mv_sel;
      grid_s2_q <= grid_s1_q;
      cmp_s1_q <= below_thresh;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
    end
  end

  // strap caught once, after the synchroniser has filled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
      config_set_q <= 4'h0;
      bus_addr_q <= 7'h00;
    end else if (ce && !strap_done_q) begin
      if (strap_wait_q == 2'h2) begin
        strap_done_q <= 1'b1;
        config_set_q <= strap_s2_q;
        bus_addr_q <= BASE_ADDR + {3'h0, strap_s2_q};
      end else begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // voltage code decode and ramp selection
  logic [11:0] code_ext;
  assign code_ext = {4'h0, code_req.code};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_mv_q <= 12'h000;
      output_off_q <= 1'b1;
      ramp_timing_q <= 4'h0;
      ramp_fast_q <= 1'b0;
    end else if (ce && code_req.valid) begin
      output_off_q <= (code_req.code == 8'h00);
      if (code_req.code == 8'h00) begin
        setpoint_mv_q <= 12'h000;
      end else if (grid_s2_q) begin
        setpoint_mv_q <= `VLSC_SP10_BASE_MV + code_ext * `VLSC_SP10_STEP_MV;
      end else begin
        setpoint_mv_q <= `VLSC_SP5_BASE_MV + code_ext * `VLSC_SP5_STEP_MV;
      end
      ramp_fast_q <= code_req.fast;
      if (code_req.fast) begin
        ramp_timing_q <= fast_ramp_config_q[`VLSC_FAST_MSB:`VLSC_FAST_LSB];
      end else begin
        ramp_timing_q <= {2'h0, slow_ramp_config_q[`VLSC_SLOW_MSB:`VLSC_SLOW_LSB]};
      end
    end
  end

  // load-line resistance in 0.01 micro-ohm and bandwidth in kHz
  logic [9:0] bw_raw;
  assign bw_raw = {6'h00, droop_range_bandwidth_q[`VLSC_BW_MSB:`VLSC_BW_LSB]} + 10'h001;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      droop_res_q <= 30'h0000000;
      ll_bw_khz_q <= 10'h000;
    end else if (ce) begin
      if (droop_range_bandwidth_q[`VLSC_RANGE_BIT]) begin
        droop_res_q <= {14'h0000, droop_resistance_q} * `VLSC_DROOP_COARSE;
      end else begin
        droop_res_q <= {14'h0000, droop_resistance_q} * `VLSC_DROOP_FINE;
      end
      if (bw_raw * `VLSC_BW_STEP_KHZ > `VLSC_BW_MAX_KHZ) begin
        ll_bw_khz_q <= `VLSC_BW_MAX_KHZ;
      end else begin
        ll_bw_khz_q <= bw_raw * `VLSC_BW_STEP_KHZ;
      end
    end
  end

  // fixed on-time pulse; falls below threshold during a pulse are ignored
  vlsc_pkg::vlsc_pulse_state_type pulse_q;
  logic [15:0] on_cnt_q;
  logic switching_seen_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= vlsc_pkg::VLSC_PULSE_IDLE;
      on_cnt_q <= 16'h0000;
      hs_gate_q <= 1'b0;
      switching_seen_q <= 1'b0;
    end else if (ce) begin
      case (pulse_q)
        vlsc_pkg::VLSC_PULSE_IDLE: begin
          if (cmp_s2_q && !cmp_s3_q && !output_off_q) begin
            pulse_q <= vlsc_pkg::VLSC_PULSE_ON;
            hs_gate_q <= 1'b1;
            on_cnt_q <= 16'h0000;
            switching_seen_q <= 1'b1;
          end
        end
        vlsc_pkg::VLSC_PULSE_ON: begin
          if (on_cnt_q == 16'(ON_CYC - 1)) begin
            pulse_q <= vlsc_pkg::VLSC_PULSE_IDLE;
            hs_gate_q <= 1'b0;
          end else begin
            on_cnt_q <= on_cnt_q + 16'h0001;
          end
        end
        default: begin
          pulse_q <= vlsc_pkg::VLSC_PULSE_IDLE;
          hs_gate_q <= 1'b0;
        end
      endcase
    end
  end

  // input current: shunt code, calculated and shunt estimates, user correction
  logic [3:0] rs_code;
  logic [7:0] rs_dec;
  logic [31:0] calc_ma, shunt_ma, base_ma, scaled_ma;
  logic signed [33:0] corr_ma;
  logic [6:0] gain_mul;
  assign rs_code = input_current_sense_cfg_q[`VLSC_RSNS_MSB:`VLSC_RSNS_LSB];
  always_comb begin
    if (rs_code == 4'h0) begin
      rs_dec = `VLSC_RSNS_0;
    end else if (rs_code == 4'h1) begin
      rs_dec = `VLSC_RSNS_1;
    end else if (rs_code > `VLSC_RSNS_TOP_CODE) begin
      rs_dec = `VLSC_RSNS_MAX;
    end else begin
      rs_dec = 8'({4'h0, rs_code} - 8'h01) * 8'h0a;
    end
  end
  always_comb begin
    calc_ma = 32'h00000000;
    if (switching_seen_q && vin_mv != 16'h0000) begin
      calc_ma = ({16'h0000, iout_ma} * {20'h00000, vout_mv}) / {16'h0000, vin_mv};
    end
    shunt_ma = ({16'h0000, shunt_uv} * 32'h0000000a) / {24'h000000, rs_dec};
    if (iin_sense_mode == 2'h0) begin
      base_ma = calc_ma;
    end else if (iin_sense_mode == 2'h1) begin
      base_ma = shunt_ma;
    end else begin
      base_ma = (calc_ma + shunt_ma) >> 1;
    end
    gain_mul = `VLSC_GAIN_UNITY + {{3{input_current_sense_cfg_q[`VLSC_GAIN_MSB]}},
      input_current_sense_cfg_q[`VLSC_GAIN_MSB:`VLSC_GAIN_LSB]};
    scaled_ma = (base_ma * {25'h0000000, gain_mul}) >> 6;
    corr_ma = $signed({2'b00, scaled_ma}) + 34'($signed(
      input_current_sense_cfg_q[`VLSC_OFS_MSB:`VLSC_OFS_LSB]));
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      use_calc_q <= 1'b0;
      use_shunt_q <= 1'b0;
      rsense_tenth_mohm_q <= 8'h00;
      iin_ma_q <= 16'h0000;
    end else if (ce) begin
      use_calc_q <= (iin_sense_mode != 2'h1);
      use_shunt_q <= (iin_sense_mode != 2'h0);
      rsense_tenth_mohm_q <= rs_dec;
      if (corr_ma < 0) begin
        iin_ma_q <= 16'h0000;
      end else if (corr_ma > 34'sh000ffff) begin
        iin_ma_q <= 16'hffff;
      end else begin
        iin_ma_q <= corr_ma[15:0];
      end
    end
  end

  a_zero_code_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && code_req.valid && code_req.code == 8'h00) |=> (output_off_q && setpoint_mv_q == 12'h000))
    else $error("zero code did not turn output off");
  a_grid_ten_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && code_req.valid && code_req.code != 8'h00 && grid_s2_q) |=>
    (setpoint_mv_q == 12'd490 + 12'd10 * {4'h0, $past(code_req.code)}))
    else $error("10 mV grid setpoint wrong");
  a_grid_five_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && code_req.valid && code_req.code != 8'h00 && !grid_s2_q) |=>
    (setpoint_mv_q == 12'd245 + 12'd5 * {4'h0, $past(code_req.code)}))
    else $error("5 mV grid setpoint wrong");
  a_strap_addr_sum: assert property (@(posedge core_clk) disable iff (!rst_n)
    (strap_done_q |-> bus_addr_q == BASE_ADDR + {3'h0, config_set_q}) and
    ($past(strap_done_q) |-> $stable(config_set_q)))
    else $error("strap address or set changed");
  a_ramp_field_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && code_req.valid && code_req.fast) |=> (ramp_timing_q == $past(fast_ramp_config_q[15:12])))
    else $error("fast ramp timing not taken");
  a_droop_weight: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && droop_range_bandwidth_q[6]) |=>
    (droop_res_q == {14'h0000, $past(droop_resistance_q)} * 30'd10000))
    else $error("coarse droop weight wrong");
  a_bw_step_size: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce |=> (ll_bw_khz_q ==
    10'd30 * ({6'h00, $past(droop_range_bandwidth_q[3:0])} + 10'd1)))
    else $error("bandwidth step wrong");
  a_pulse_on_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    (hs_gate_q |-> on_cnt_q < 16'(ON_CYC)) and ($rose(hs_gate_q) |-> on_cnt_q == 16'h0000) and
    ($fell(hs_gate_q) |-> $past(on_cnt_q) == 16'(ON_CYC - 1)))
    else $error("on-time pulse length wrong");
  a_sense_mode_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    ce |=> (use_calc_q == ($past(iin_sense_mode[1]) | !$past(iin_sense_mode[0])) &&
    use_shunt_q == ($past(iin_sense_mode[1]) | $past(iin_sense_mode[0]))))
    else $error("sense mode decode wrong");
  a_shunt_top_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && rs_code >= 4'hb) |=> (rsense_tenth_mohm_q == 8'd100))
    else $error("shunt code above 10 not 10 milliohm");
endmodule
`default_nettype wire

// file: vlsc_defs.svh
// offsets, field positions, reset values and timing figures of the
// regulator configuration block; definitions only
`ifndef VLSC_DEFS_SVH
`define VLSC_DEFS_SVH

`define VLSC_CLK_MHZ 250
`define VLSC_ON_TIME_NS 100

`define VLSC_ADDR_SLOW 12'h044
`define VLSC_ADDR_FAST 12'h046
`define VLSC_ADDR_IIN 12'h066
`define VLSC_ADDR_LLBW 12'h06a
`define VLSC_ADDR_DROOP 12'h250

`define VLSC_RST_SLOW 16'h0000
`define VLSC_RST_FAST 16'h0000
`define VLSC_RST_IIN 16'h0000
`define VLSC_RST_LLBW 16'h0000
`define VLSC_RST_DROOP 16'h0000

`define VLSC_SLOW_LSB 0
`define VLSC_SLOW_MSB 1
`define VLSC_FAST_LSB 12
`define VLSC_FAST_MSB 15
`define VLSC_OFS_LSB 8
`define VLSC_OFS_MSB 13
`define VLSC_GAIN_LSB 4
`define VLSC_GAIN_MSB 7
`define VLSC_RSNS_LSB 0
`define VLSC_RSNS_MSB 3
`define VLSC_RANGE_BIT 6
`define VLSC_BW_LSB 0
`define VLSC_BW_MSB 3

`define VLSC_SP10_BASE_MV 12'h1ea
`define VLSC_SP10_STEP_MV 12'h00a
`define VLSC_SP5_BASE_MV 12'h0f5
`define VLSC_SP5_STEP_MV 12'h005

`define VLSC_DROOP_FINE 30'h00007a1
`define VLSC_DROOP_COARSE 30'h0002710

`define VLSC_BW_STEP_KHZ 10'h01e
`define VLSC_BW_MAX_KHZ 10'h1f4

`define VLSC_RSNS_0 8'h02
`define VLSC_RSNS_1 8'h05
`define VLSC_RSNS_MAX 8'h64
`define VLSC_RSNS_TOP_CODE 4'ha

`define VLSC_GAIN_UNITY 7'h40
`endif

// file: vlsc_pkg.sv
// types shared by the regulator configuration block
package vlsc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } vlsc_reg_req_type;

  typedef struct packed {
    logic valid;
    logic fast;
    logic [7:0] code;
  } vlsc_code_req_type;

  typedef enum logic [1:0] {
    VLSC_PULSE_IDLE = 2'b01,
    VLSC_PULSE_ON = 2'b10
  } vlsc_pulse_state_type;
endpackage

// file: vlsc_host_model.sv
// host model: drives the register port and the voltage code port
// assumes a single core_clk domain, requests taken on rising edges
`timescale 1ns/1ps
`default_nettype none
module vlsc_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output var vlsc_pkg::vlsc_reg_req_type reg_req,
  input wire logic [15:0] reg_rdata_q,
  // voltage code port
  output var vlsc_pkg::vlsc_code_req_type code_req
);
  initial begin
    reg_req = '0;
    code_req = '0;
  end

  // one access; on release wr and rd drop to zero, address and data show the inverse of the last value
  task automatic reg_access(input logic wr, input logic [11:0] a, input logic [15:0] d,
      output logic [15:0] q);
    @(posedge core_clk);
    #1;
    reg_req = {wr, ~wr, a, d};
    @(posedge core_clk);
    #1;
    reg_req = {2'b00, ~a, ~d};
    q = reg_rdata_q;
  endtask

  task automatic send_code(input logic [7:0] c, input logic f);
    @(posedge core_clk);
    #1;
    code_req = {1'b1, f, c};
    @(posedge core_clk);
    #1;
    code_req = {1'b0, ~f, ~c};
  endtask
endmodule
`default_nettype wire

// file: vlsc_top_test.sv
// self-checking bench of the regulator configuration block
// assumes the host model on the register and code ports, pins driven here
`include "vlsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define VLSC_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module vlsc_top_test;
  logic core_clk, rst_n, ce, grid_10mv_sel, below_thresh;
  logic [3:0] strap_select_pin;
  logic [1:0] iin_sense_mode;
  logic [15:0] iout_ma, vin_mv, shunt_uv, reg_rdata_q, iin_ma_q;
  logic [11:0] vout_mv, setpoint_mv_q;
  logic output_off_q, ramp_fast_q, strap_done_q, hs_gate_q, use_calc_q, use_shunt_q;
  logic [3:0] ramp_timing_q, config_set_q;
  logic [6:0] bus_addr_q;
  logic [29:0] droop_res_q;
  logic [9:0] ll_bw_khz_q;
  logic [7:0] rsense_tenth_mohm_q;
  vlsc_pkg::vlsc_reg_req_type reg_req;
  vlsc_pkg::vlsc_code_req_type code_req;
  int error_cnt, n_compared, k, g, n;
  logic [11:0] regs [5] = '{`VLSC_ADDR_SLOW, `VLSC_ADDR_FAST, `VLSC_ADDR_IIN,
      `VLSC_ADDR_LLBW, `VLSC_ADDR_DROOP};
  logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h02, 8'h50, 8'hff};

  vlsc_host_model host_u (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
      .code_req(code_req));
  vlsc_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
      .reg_rdata_q(reg_rdata_q), .code_req(code_req), .grid_10mv_sel(grid_10mv_sel),
      .setpoint_mv_q(setpoint_mv_q), .output_off_q(output_off_q), .ramp_timing_q(ramp_timing_q),
      .ramp_fast_q(ramp_fast_q), .strap_select_pin(strap_select_pin),
      .strap_done_q(strap_done_q), .config_set_q(config_set_q), .bus_addr_q(bus_addr_q),
      .droop_res_q(droop_res_q), .ll_bw_khz_q(ll_bw_khz_q), .below_thresh(below_thresh),
      .hs_gate_q(hs_gate_q), .iin_sense_mode(iin_sense_mode), .iout_ma(iout_ma),
      .vout_mv(vout_mv), .vin_mv(vin_mv), .shunt_uv(shunt_uv), .use_calc_q(use_calc_q),
      .use_shunt_q(use_shunt_q), .rsense_tenth_mohm_q(rsense_tenth_mohm_q), .iin_ma_q(iin_ma_q));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] q;
    host_u.reg_access(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] q;
    host_u.reg_access(1'b0, a, 16'h0000, q);
    `VLSC_CHK(q, e)
  endtask

  task automatic code(input logic [7:0] c, input logic f);
    host_u.send_code(c, f);
    tick(2);
  endtask

  // raise the comparator pin, count the gate pulse, re-trigger during it
  task automatic pulse_len(output int len);
    int w;
    len = 0;
    below_thresh = 1'b1;
    for (w = 0; w < 10 && hs_gate_q !== 1'b1; w++) tick(1);
    while (hs_gate_q === 1'b1 && len < 100) begin
      below_thresh = (len >= 5 && len < 8);
      len++;
      tick(1);
    end
    below_thresh = 1'b0;
    tick(12);
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    #300000;
    error_cnt++;
    stop_test();
  end

  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    grid_10mv_sel = 1'b1;
    strap_select_pin = 4'h9;
    below_thresh = 1'b0;
    iin_sense_mode = 2'h0;
    iout_ma = 16'h2710;
    vout_mv = 12'h3e8;
    vin_mv = 16'h2ee0;
    shunt_uv = 16'h03e8;
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    `VLSC_CHK(output_off_q, 1'b1)
    for (k = 0; k < 10 && strap_done_q !== 1'b1; k++) tick(1);
    if (strap_done_q !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t strap wait timed out", $time);
      stop_test();
    end
    `VLSC_CHK(config_set_q, 4'h9)
    `VLSC_CHK(bus_addr_q, 7'h49)
    for (k = 0; k < 5; k++) rd_chk(regs[k], 16'h0000);
    tdone("reset");
    for (k = 0; k < 5; k++) wr(regs[k], 16'ha5a0 ^ 16'(k));
    wr(12'h048, 16'hffff);
    for (k = 0; k < 5; k++) rd_chk(regs[k], 16'ha5a0 ^ 16'(k));
    rd_chk(12'h048, 16'h0000);
    ce = 1'b0;
    wr(`VLSC_ADDR_SLOW, 16'h1234);
    ce = 1'b1;
    rd_chk(`VLSC_ADDR_SLOW, 16'ha5a0);
    tdone("registers");
    for (g = 1; g >= 0; g--) begin
      grid_10mv_sel = g[0];
      tick(4);
      for (k = 0; k < 5; k++) begin
        code(codes[k], 1'b0);
        `VLSC_CHK(output_off_q, codes[k] == 8'h00)
        if (codes[k] != 8'h00 && g == 1) `VLSC_CHK(setpoint_mv_q, 12'(490 + 10 * codes[k]))
        if (codes[k] != 8'h00 && g == 0) `VLSC_CHK(setpoint_mv_q, 12'(245 + 5 * codes[k]))
      end
    end
    tdone("codes");
    grid_10mv_sel = 1'b1;
    wr(`VLSC_ADDR_SLOW, 16'hfff2);
    wr(`VLSC_ADDR_FAST, 16'h7fff);
    tick(4);
    code(8'h40, 1'b0);
    `VLSC_CHK(ramp_timing_q, 4'h2)
    `VLSC_CHK(ramp_fast_q, 1'b0)
    code(8'h40, 1'b1);
    `VLSC_CHK(ramp_timing_q, 4'h7)
    `VLSC_CHK(ramp_fast_q, 1'b1)
    `VLSC_CHK(setpoint_mv_q, 12'h46a)
    tdone("ramp");
    wr(`VLSC_ADDR_DROOP, 16'h0100);
    for (k = 0; k < 16; k++) begin
      wr(`VLSC_ADDR_LLBW, 16'(k));
      tick(2);
      `VLSC_CHK(ll_bw_khz_q, 10'(30 * (k + 1)))
    end
    `VLSC_CHK(droop_res_q, 30'h007a100)
    wr(`VLSC_ADDR_LLBW, 16'h0043);
    tick(2);
    `VLSC_CHK(droop_res_q, 30'h0271000)
    `VLSC_CHK(ll_bw_khz_q, 10'h078)
    tdone("load line");
    pulse_len(n);
    `VLSC_CHK(n, 25)
    `VLSC_CHK(hs_gate_q, 1'b0)
    code(8'h00, 1'b0);
    pulse_len(n);
    `VLSC_CHK(n, 0)
    tdone("pulse");
    wr(`VLSC_ADDR_IIN, 16'h0000);
    tick(3);
    `VLSC_CHK(iin_ma_q, 16'h0341)
    wr(`VLSC_ADDR_IIN, 16'h0500);
    tick(3);
    `VLSC_CHK(iin_ma_q, 16'h0346)
    wr(`VLSC_ADDR_IIN, 16'h0040);
    tick(3);
    `VLSC_CHK(iin_ma_q, 16'h0375)
    for (k = 0; k < 16; k++) begin
      wr(`VLSC_ADDR_IIN, 16'(k));
      tick(2);
      `VLSC_CHK(rsense_tenth_mohm_q, 8'(k == 0 ? 2 : k == 1 ? 5 : k > 10 ? 100 : 10 * (k - 1)))
    end
    for (k = 0; k < 4; k++) begin
      iin_sense_mode = 2'(k);
      tick(2);
      `VLSC_CHK(use_calc_q, k != 1)
      `VLSC_CHK(use_shunt_q, k != 0)
    end
    wr(`VLSC_ADDR_IIN, 16'h0005);
    iin_sense_mode = 2'h1;
    tick(3);
    `VLSC_CHK(iin_ma_q, 16'h00fa)
    iin_sense_mode = 2'h2;
    tick(3);
    `VLSC_CHK(iin_ma_q, 16'h021d)
    tdone("input current");
    stop_test();
  end
endmodule
`default_nettype wire
